// ---- pmsmp_pkg.sv ----
/*
 Shared constants for the station-management host: register map, field
 positions, frame layout, link modes and timing.
 Assumes a single 10 MHz system clock.
*/
package pmsmp_pkg;
	localparam int CLK_HZ      = 10_000_000;
	localparam int MDC_MAX_HZ  = 25_000_000;
	localparam int MDC_HZ      = 1_000_000;
	localparam int MDC_HALF_CYC = (CLK_HZ / (2 * MDC_HZ)) > 0 ?
		(CLK_HZ / (2 * MDC_HZ)) : 1;
	localparam logic [3:0] MDC_HALF_M1 = 4'(MDC_HALF_CYC - 1);

	localparam logic [5:0] PRE_LAST   = 6'h1f;
	localparam logic [5:0] FRAME_LAST = 6'h1f;
	localparam logic [5:0] TA_FIRST   = 6'h0e;
	localparam logic [5:0] TA_SECOND  = 6'h0f;
	localparam logic [5:0] DATA_FIRST = 6'h10;
	localparam logic [1:0] FR_START   = 2'h1;
	localparam logic [1:0] OP_READ    = 2'h2;
	localparam logic [1:0] OP_WRITE   = 2'h1;
	localparam logic [1:0] TA_WRITE   = 2'h2;

	localparam logic [4:0] BASIC_MODE_STATUS_ADDR = 5'h01;
	localparam int         PRE_SUPP_BIT = 6;

	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_ADDR  = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_STAT  = 8'h0c;
	localparam logic [7:0] OFF_RDATA = 8'h10;

	localparam int CTRL_GO = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_NOPRE = 2;
	localparam int CTRL_PRST = 3;
	localparam int CTRL_MODE = 4;
	localparam int ADDR_PHY = 8;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_NORESP = 2;
	localparam int ST_CRS = 3;
	localparam int ST_COL = 4;
	localparam int ST_SYNC = 5;
	localparam int ST_SUPP = 6;

	localparam logic [1:0] MODE_MII  = 2'h0;
	localparam logic [1:0] MODE_RMII = 2'h1;
	localparam logic [1:0] MODE_SERIAL = 2'h2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] SYNC_RST = 3'h1;

	typedef enum logic [2:0] {
		PMSMP_IDLE  = 3'b000,
		PMSMP_ARM   = 3'b001,
		PMSMP_PRE   = 3'b010,
		PMSMP_FRAME = 3'b011,
		PMSMP_GAP   = 3'b100
	} pmsmp_state_e;
endpackage

// ---- pmsmp_mdc_gen.sv ----
/*
 Management clock divider: free-running clock plus one-cycle pulses
 marking its rising and falling edges.
 Assumes the shared package and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module pmsmp_mdc_gen
	import pmsmp_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	output logic      mdc,
	output logic      mdc_rise,
	output logic      mdc_fall
);
	logic [3:0] cnt_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_r    <= 4'h0;
			mdc      <= 1'b0;
			mdc_rise <= 1'b0;
			mdc_fall <= 1'b0;
		end else if (cnt_r == MDC_HALF_M1) begin
			cnt_r    <= 4'h0;
			mdc      <= ~mdc;
			mdc_rise <= ~mdc;
			mdc_fall <= mdc;
		end else begin
			cnt_r    <= cnt_r + 4'h1;
			mdc_rise <= 1'b0;
			mdc_fall <= 1'b0;
		end
	end
endmodule

// ---- pmsmp_host.sv ----
/*
 Station-management host for a 10/100 PHY: AXI4-Lite register slave,
 management frame engine on MDC/MDIO, PHY reset and mode strap driver,
 carrier and collision monitor.
 Assumes an external pull-up on MDIO and one 10 MHz clock.
*/
// Summary of operation
// - Reduced mode moves two bits per 50 MHz reference clock.
// - Reduced mode at 10 Mb/s samples once per ten reference clocks.
// - Serial mode moves one bit per 10 MHz clock.
// - Host keeps MDC at or below 25 MHz.
// - Host sends 32 ones before the first frame.
// - After errors or reset the host sends a fresh preamble.
// - Every frame starts with zero then one.
// - On reads the host releases MDIO over turnaround and data.
// - On writes the host drives turnaround one, zero, then data.
// - At least one idle bit separates consecutive frames.
`timescale 1ns/1ns
module pmsmp_host
	import pmsmp_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output wire logic        mdc,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe,
	output logic             phy_rst_n,
	output logic [1:0]       strap_mode,
	input  wire logic        crs_i,
	input  wire logic        col_i
);
	pmsmp_state_e state_r;
	logic         mdc_rise;
	logic         mdc_fall;
	logic [2:0]   sync1_r;
	logic [2:0]   sync2_r;
	logic         mdio_s;
	logic [7:0]   aw_addr_r;
	logic [31:0]  w_data_r;
	logic [3:0]   w_strb_r;
	logic         aw_got_r;
	logic         w_got_r;
	logic         wr_fire;
	logic [7:0]   wr_addr;
	logic [7:0]   stat_clr;
	logic         go_p;
	logic         done_p;
	logic         ctrl_rd_r;
	logic         ctrl_nopre_r;
	logic         ctrl_prst_r;
	logic [1:0]   ctrl_mode_r;
	logic [4:0]   reg_addr_r;
	logic [4:0]   phy_addr_r;
	logic [15:0]  wdata_r;
	logic [15:0]  rdata_r;
	logic [15:0]  rd_sr_r;
	logic [31:0]  frame_sr_r;
	logic [5:0]   idx_r;
	logic [5:0]   idx_nxt;
	logic         op_rd_r;
	logic [4:0]   op_reg_r;
	logic         need_pre_r;
	logic         frame_err_r;
	logic         done_r;
	logic         noresp_r;
	logic         crs_seen_r;
	logic         col_seen_r;
	logic         synced_r;
	logic         supp_ok_r;
	logic [31:0]  rd_mux;
	logic         rd_hit;

	pmsmp_mdc_gen u_mdc (
		.clock    (clock),
		.rst_n    (rst_n),
		.mdc      (mdc),
		.mdc_rise (mdc_rise),
		.mdc_fall (mdc_fall)
	);

	// Pins are asynchronous to the system clock
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
		end else begin
			sync1_r <= {col_i, crs_i, mdio_i};
			sync2_r <= sync1_r;
		end
	end
	assign mdio_s = sync2_r[0];

	// AXI write channels, taken in either order
	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
	assign wr_addr = aw_addr_r;
	assign go_p = wr_fire && wr_addr == OFF_CTRL && w_strb_r[0] &&
		w_data_r[CTRL_GO] && state_r == PMSMP_IDLE;
	assign stat_clr = (wr_fire && wr_addr == OFF_STAT && w_strb_r[0]) ?
		w_data_r[7:0] : 8'h00;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h0;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_got_r && !s_axi_bvalid &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_got_r && !s_axi_bvalid &&
				!(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r  <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_addr == OFF_CTRL || wr_addr == OFF_ADDR ||
					wr_addr == OFF_WDATA || wr_addr == OFF_STAT ||
					wr_addr == OFF_RDATA) begin
					s_axi_bresp <= RESP_OKAY;
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_rd_r    <= 1'b0;
			ctrl_nopre_r <= 1'b0;
			ctrl_prst_r  <= 1'b1;
			ctrl_mode_r  <= MODE_MII;
			reg_addr_r   <= 5'h00;
			phy_addr_r   <= 5'h00;
			wdata_r      <= 16'h0;
		end else if (wr_fire) begin
			if (wr_addr == OFF_CTRL && w_strb_r[0]) begin
				ctrl_rd_r    <= w_data_r[CTRL_RD];
				ctrl_nopre_r <= w_data_r[CTRL_NOPRE];
				ctrl_prst_r  <= w_data_r[CTRL_PRST];
				ctrl_mode_r  <= w_data_r[CTRL_MODE +: 2];
			end else if (wr_addr == OFF_ADDR) begin
				if (w_strb_r[0]) reg_addr_r <= w_data_r[4:0];
				if (w_strb_r[1]) phy_addr_r <= w_data_r[ADDR_PHY +: 5];
			end else if (wr_addr == OFF_WDATA) begin
				if (w_strb_r[0]) wdata_r[7:0]  <= w_data_r[7:0];
				if (w_strb_r[1]) wdata_r[15:8] <= w_data_r[15:8];
			end
		end
	end

	// Strap follows software only while the PHY is held in reset,
	// so mode changes reach the PHY solely at its reset release
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			phy_rst_n  <= 1'b0;
			strap_mode <= MODE_MII;
		end else begin
			phy_rst_n <= !ctrl_prst_r;
			if (ctrl_prst_r) strap_mode <= ctrl_mode_r;
		end
	end

	// AXI read channel
	always_comb begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		if (s_axi_araddr == OFF_CTRL) begin
			rd_mux[CTRL_RD]       = ctrl_rd_r;
			rd_mux[CTRL_NOPRE]    = ctrl_nopre_r;
			rd_mux[CTRL_PRST]     = ctrl_prst_r;
			rd_mux[CTRL_MODE +: 2] = ctrl_mode_r;
		end else if (s_axi_araddr == OFF_ADDR) begin
			rd_mux[4:0]           = reg_addr_r;
			rd_mux[ADDR_PHY +: 5] = phy_addr_r;
		end else if (s_axi_araddr == OFF_WDATA) begin
			rd_mux[15:0] = wdata_r;
		end else if (s_axi_araddr == OFF_STAT) begin
			rd_mux[ST_BUSY]   = state_r != PMSMP_IDLE;
			rd_mux[ST_DONE]   = done_r;
			rd_mux[ST_NORESP] = noresp_r;
			rd_mux[ST_CRS]    = crs_seen_r;
			rd_mux[ST_COL]    = col_seen_r;
			rd_mux[ST_SYNC]   = synced_r;
			rd_mux[ST_SUPP]   = supp_ok_r;
		end else if (s_axi_araddr == OFF_RDATA) begin
			rd_mux[15:0] = rdata_r;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// Frame engine; MDIO changes after MDC falls, PHY samples on rise
	assign idx_nxt = idx_r + 6'h01;
	assign done_p  = state_r == PMSMP_GAP && mdc_fall;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r    <= PMSMP_IDLE;
			idx_r      <= 6'h00;
			frame_sr_r <= 32'h0;
			op_rd_r    <= 1'b0;
			op_reg_r   <= 5'h00;
			need_pre_r <= 1'b1;
			mdio_o     <= 1'b0;
			mdio_oe    <= 1'b0;
		end else begin
			case (state_r)
			PMSMP_IDLE: begin
				if (go_p) begin
					state_r    <= PMSMP_ARM;
					// Go comes with its options in one write: use that word
					frame_sr_r <= {FR_START,
						w_data_r[CTRL_RD] ? OP_READ : OP_WRITE,
						phy_addr_r, reg_addr_r, TA_WRITE, wdata_r};
					op_rd_r    <= w_data_r[CTRL_RD];
					op_reg_r   <= reg_addr_r;
					need_pre_r <= !(w_data_r[CTRL_NOPRE] && synced_r &&
						supp_ok_r);
				end
			end
			PMSMP_ARM: begin
				if (mdc_fall) begin
					idx_r   <= 6'h00;
					mdio_oe <= 1'b1;
					if (need_pre_r) begin
						state_r <= PMSMP_PRE;
						mdio_o  <= 1'b1;
					end else begin
						state_r <= PMSMP_FRAME;
						mdio_o  <= frame_sr_r[31];
					end
				end
			end
			PMSMP_PRE: begin
				if (mdc_fall) begin
					if (idx_r == PRE_LAST) begin
						state_r <= PMSMP_FRAME;
						idx_r   <= 6'h00;
						mdio_o  <= frame_sr_r[31];
					end else begin
						idx_r <= idx_nxt;
					end
				end
			end
			PMSMP_FRAME: begin
				if (mdc_fall) begin
					if (idx_r == FRAME_LAST) begin
						state_r <= PMSMP_GAP;
						mdio_oe <= 1'b0;
					end else begin
						idx_r      <= idx_nxt;
						frame_sr_r <= {frame_sr_r[30:0], 1'b0};
						mdio_o     <= frame_sr_r[30];
						mdio_oe    <= !(op_rd_r && idx_nxt >= TA_FIRST);
					end
				end
			end
			PMSMP_GAP: begin
				if (mdc_fall) state_r <= PMSMP_IDLE;
			end
			default: state_r <= PMSMP_IDLE;
			endcase
		end
	end

	// Read sampling just before each rising MDC edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_sr_r     <= 16'h0;
			frame_err_r <= 1'b0;
		end else if (go_p) begin
			frame_err_r <= 1'b0;
		end else if (state_r == PMSMP_FRAME && mdc_rise && op_rd_r) begin
			if (idx_r == TA_SECOND && mdio_s) frame_err_r <= 1'b1;
			if (idx_r >= DATA_FIRST) rd_sr_r <= {rd_sr_r[14:0], mdio_s};
		end
	end

	// Status flags; a set in the clearing cycle wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_r    <= 16'h0;
			done_r     <= 1'b0;
			noresp_r   <= 1'b0;
			crs_seen_r <= 1'b0;
			col_seen_r <= 1'b0;
		end else begin
			if (done_p && op_rd_r && !frame_err_r) rdata_r <= rd_sr_r;
			done_r     <= (done_r && !stat_clr[ST_DONE]) || done_p;
			noresp_r   <= (noresp_r && !stat_clr[ST_NORESP]) ||
				(done_p && frame_err_r);
			crs_seen_r <= (crs_seen_r && !stat_clr[ST_CRS]) || sync2_r[1];
			col_seen_r <= (col_seen_r && !stat_clr[ST_COL]) || sync2_r[2];
		end
	end

	// Sync is lost on PHY reset or a frame nobody answered
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			synced_r  <= 1'b0;
			supp_ok_r <= 1'b0;
		end else if (ctrl_prst_r) begin
			synced_r  <= 1'b0;
			supp_ok_r <= 1'b0;
		end else if (done_p) begin
			synced_r <= !frame_err_r;
			if (frame_err_r) begin
				supp_ok_r <= 1'b0;
			end else if (op_rd_r && op_reg_r == BASIC_MODE_STATUS_ADDR) begin
				supp_ok_r <= rd_sr_r[PRE_SUPP_BIT];
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_start_bits;
		(mdio_oe && !mdio_o) ##10 (mdio_oe && mdio_o);
	endsequence
	sequence s_wr_turn;
		(mdio_oe && mdio_o) ##10 (mdio_oe && !mdio_o);
	endsequence

	property p_mdc_rate;
		$rose(mdc) |-> mdc[*5] ##1 !mdc;
	endproperty
	a_mdc_rate: assert property (p_mdc_rate) else $error("MDC high too short");

	property p_pre_ones;
		state_r == PMSMP_PRE |-> mdio_oe && mdio_o;
	endproperty
	a_pre_ones: assert property (p_pre_ones) else $error("preamble not one");

	property p_first_pre;
		go_p && !synced_r |=> need_pre_r;
	endproperty
	a_first_pre: assert property (p_first_pre) else $error("preamble skipped");

	property p_resync;
		done_p && frame_err_r |=> !synced_r;
	endproperty
	a_resync: assert property (p_resync) else $error("sync kept on error");

	property p_start;
		$rose(state_r == PMSMP_FRAME) |-> s_start_bits;
	endproperty
	a_start: assert property (p_start) else $error("bad start pattern");

	property p_rd_release;
		state_r == PMSMP_FRAME && op_rd_r && idx_r >= TA_FIRST |-> !mdio_oe;
	endproperty
	a_rd_release: assert property (p_rd_release) else $error("drove on read");

	property p_wr_turn;
		$rose(state_r == PMSMP_FRAME && !op_rd_r && idx_r == TA_FIRST)
			|-> s_wr_turn;
	endproperty
	a_wr_turn: assert property (p_wr_turn) else $error("bad write turnaround");

	property p_gap;
		state_r == PMSMP_GAP |-> !mdio_oe;
	endproperty
	a_gap: assert property (p_gap) else $error("no idle bit");

	property p_strap;
		!ctrl_prst_r |=> $stable(strap_mode);
	endproperty
	a_strap: assert property (p_strap) else $error("strap moved live");

	property p_supp;
		go_p && !supp_ok_r |=> need_pre_r;
	endproperty
	a_supp: assert property (p_supp) else $error("unsupported skip");

	property p_len;
		$rose(state_r == PMSMP_GAP) |-> $past(idx_r) == FRAME_LAST;
	endproperty
	a_len: assert property (p_len) else $error("frame length wrong");
endmodule

// ---- pmsmp_phy_model.sv ----
/*
 Behavioural PHY management port: 32 registers on MDC/MDIO, preamble
 hunt, start/opcode/turnaround checks, read data driven after MDC fall.
 Assumes the host makes MDC and the bench resolves the pulled-up line.
*/
`timescale 1ns/1ns
module pmsmp_phy_model
	import pmsmp_pkg::*;
#(
	parameter logic [4:0]  PHY_ADDR = 5'h05,
	parameter logic [15:0] BMS_VAL  = 16'h1a45
)(
	input  wire logic mdc,
	input  wire logic phy_rst_n,
	input  wire logic mdio,
	output logic      m_o,
	output logic      m_oe
);
	logic [15:0] regs [32];
	logic [15:0] sh;
	logic [15:0] rdv;
	logic [5:0]  ones;
	logic [5:0]  idx;
	logic [4:0]  ra;
	logic        synced;
	logic        rd;
	logic        talk;
	logic        bad;

	always @(posedge mdc or negedge phy_rst_n) begin
		if (!phy_rst_n) begin
			foreach (regs[i]) regs[i] = 16'h0;
			regs[BASIC_MODE_STATUS_ADDR] = BMS_VAL;
			ones = 6'h0;
			idx = 6'h0;
			synced = 1'h0;
			talk = 1'h0;
		end else if (idx == 6'h0) begin
			if (mdio && ones != 6'h3f)
				ones++;
			else if (!mdio && (synced ? ones != 6'h0 : ones >= 6'h20))
				idx = 6'h1;
			else if (!mdio)
				ones = 6'h0;
		end else begin
			bad = 1'h0;
			sh = {sh[14:0], mdio};
			if (idx == 6'h1 && !mdio)
				bad = 1'h1;
			if (idx == 6'h3 && sh[1:0] != 2'h2 && sh[1:0] != 2'h1)
				bad = 1'h1;
			if (idx == 6'h3)
				rd = sh[1];
			if (idx == 6'h8)
				talk = (sh[4:0] == PHY_ADDR);
			if (idx == 6'hd) begin
				ra = sh[4:0];
				rdv = regs[sh[4:0]];
			end
			if (idx == 6'hf && !rd && sh[1:0] != 2'h2)
				bad = 1'h1;
			if (idx == 6'h1f && !rd && talk &&
				ra != BASIC_MODE_STATUS_ADDR)
				regs[ra] = sh;
			ones = 6'h0;
			synced = !bad;
			idx = (bad || idx == 6'h1f) ? 6'h0 : idx + 6'h1;
		end
	end

	// Drive only after the fall, so the line settles well before the rise
	always @(negedge mdc or negedge phy_rst_n) begin
		if (!phy_rst_n) begin
			m_oe <= 1'h0;
			m_o <= 1'h0;
		end else begin
			m_oe <= rd && talk && idx >= 6'hf;
			m_o <= (idx == 6'hf) ? 1'h0 : rdv[4'(6'h1f - idx)];
		end
	end
endmodule

// ---- pmsmp_host_test.sv ----
/*
 Self-checking bench for the management host: AXI4-Lite tasks, a line
 monitor on MDC/MDIO and a PHY model behind a pulled-up MDIO.
 Assumes the shared package and a 10 MHz clock.
*/
`timescale 1ns/1ns
module pmsmp_host_test
	import pmsmp_pkg::*;
;
	localparam logic [4:0]  PHYA = 5'h05;
	localparam logic [15:0] BMS  = 16'h1a45;
	logic        clock = 1'h0, rst_n = 1'h0;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0, crs = 1'h0, col = 1'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, strap, op;
	logic        mdc, mdio_o, mdio_oe, m_o, m_oe, prst_n;
	wire         line = mdio_oe ? mdio_o : (m_oe ? m_o : 1'h1);
	int          num_errors = 0, tests_run = 0, wd = 0;
	int          run = 0, fi = 0, last_run = 0;
	int          drv = 0, last_drv = 0;
	time         t_last = 0;

	pmsmp_host pmsmp_host_i (.clock(clock), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .mdc(mdc),
		.mdio_i(line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
		.phy_rst_n(prst_n), .strap_mode(strap), .crs_i(crs), .col_i(col));
	pmsmp_phy_model #(.PHY_ADDR(PHYA), .BMS_VAL(BMS)) pmsmp_phy_model_i (
		.mdc(mdc), .phy_rst_n(prst_n), .mdio(line), .m_o(m_o), .m_oe(m_oe));

	always #50 clock = ~clock;

	task automatic close_out;
		$display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Hang guard: all frames together need well under this
	always @(posedge clock) begin
		wd++;
		if (wd == 40000) begin
			num_errors++;
			$display("BAD t=%0t run did not finish", $time);
			close_out;
		end
	end

	// Line watcher; frame bits counted from the start zero.
	// Pull-up ones with a free MDC would hide a missing preamble,
	// so only ones that the host drives count towards it.
	always @(posedge mdc) begin
		chk(32'(($time - t_last) >= 40), 32'h1, "mdc too fast");
		t_last = $time;
		if (!rst_n) begin
			run = 0;
			drv = 0;
			fi = 0;
		end else if (fi == 0) begin
			if (line === 1'h1) begin
				run++;
				drv = (mdio_oe === 1'h1) ? drv + 1 : 0;
			end else begin
				last_run = run;
				last_drv = drv;
				run = 0;
				drv = 0;
				fi = 1;
			end
		end else begin
			if (fi == 1)
				chk(32'(line), 32'h1, "start bit");
			if (fi == 2 || fi == 3)
				op = {op[0], line};
			if (op == 2'h2 && fi >= 14)
				chk(32'(mdio_oe), 32'h0, "host drove read");
			if (op == 2'h1 && fi == 14)
				chk(32'(line), 32'h1, "turnaround 1");
			if (op == 2'h1 && fi == 15)
				chk(32'(line), 32'h0, "turnaround 2");
			fi = (fi == 31) ? 0 : fi + 1;
		end
	end

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		aw = 1'h0;
		w = 1'h0;
		while (!(aw && w)) begin
			@(posedge clock);
			if (awvalid && awready === 1'h1) begin
				aw = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready === 1'h1) begin
				w = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge clock); while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clock); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge clock); while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	// One management frame; returns status at completion and read data
	task automatic mop(input logic rd, input logic [4:0] pa, ra,
		input logic [15:0] d, input logic np, output logic [31:0] st, rv);
		logic [1:0] r;
		axi_wr(OFF_ADDR, {19'h0, pa, 3'h0, ra}, r);
		axi_wr(OFF_WDATA, {16'h0, d}, r);
		axi_wr(OFF_CTRL, {26'h0, MODE_RMII, 1'h0, np, rd, 1'h1}, r);
		st = 32'h0;
		while (st[ST_DONE] !== 1'h1)
			axi_rd(OFF_STAT, st, r);
		axi_rd(OFF_RDATA, rv, r);
		axi_wr(OFF_STAT, 32'h0000001e, r);
	endtask

	initial begin
		logic [31:0] st, rv;
		logic [15:0] shadow [32];
		logic [15:0] d;
		logic [1:0]  r;
		logic [4:0]  ra;
		logic        np;
		foreach (shadow[i]) shadow[i] = 16'h0;
		void'($urandom(36528));
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		axi_rd(OFF_CTRL, rv, r);
		chk(rv, 32'h00000008, "ctrl reset value");
		axi_rd(OFF_STAT, rv, r);
		chk(rv, 32'h0, "status reset value");
		chk(32'(prst_n), 32'h0, "phy held in reset");
		axi_rd(8'h14, rv, r);
		chk({rv[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
		axi_wr(8'h20, 32'h1, r);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
		$display("test registers done");
		axi_wr(OFF_CTRL, 32'h00000018, r);
		axi_wr(OFF_CTRL, 32'h00000010, r);
		axi_wr(OFF_CTRL, 32'h00000020, r);
		chk({30'h0, strap}, 32'(MODE_RMII), "strap moved");
		chk(32'(prst_n), 32'h1, "phy released");
		$display("test strap done");
		mop(1'h1, PHYA, 5'h01, 16'h0, 1'h1, st, rv);
		chk(32'(last_drv), 32'h20, "first preamble");
		chk(rv, {16'h0, BMS}, "status register read");
		axi_rd(OFF_STAT, st, r);
		chk(32'(st[6:5]), 32'h3, "synced and suppression");
		$display("test first read done");
		for (int i = 0; i < 12; i++) begin
			ra = (i == 0) ? 5'h1f : 5'($urandom_range(31, 2));
			d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : 16'($urandom);
			np = 1'($urandom_range(1, 0));
			shadow[ra] = d;
			mop(1'h0, PHYA, ra, d, np, st, rv);
			chk(32'(last_run >= 1), 32'h1, "idle gap");
			chk(32'(last_drv), np ? 32'h0 : 32'h20, "preamble");
			mop(1'h1, PHYA, ra, 16'h0, np, st, rv);
			chk(rv, {16'h0, shadow[ra]}, "read back");
			chk(32'(st[ST_NORESP]), 32'h0, "spurious no-response");
		end
		$display("test random traffic done");
		mop(1'h1, 5'h1a, 5'h02, 16'h0, 1'h1, st, rv);
		chk(32'(st[ST_NORESP]), 32'h1, "foreign address answered");
		chk(rv, {16'h0, shadow[ra]}, "read data changed");
		mop(1'h1, PHYA, 5'h01, 16'h0, 1'h1, st, rv);
		chk(32'(last_drv), 32'h20, "resync preamble");
		chk(rv, {16'h0, BMS}, "read after resync");
		$display("test no-response done");
		for (int k = ST_CRS; k <= ST_COL; k++) begin
			@(posedge clock);
			crs <= (k == ST_CRS);
			col <= (k == ST_COL);
			repeat ($urandom_range(4, 2)) @(posedge clock);
			crs <= 1'h0;
			col <= 1'h0;
			repeat (4) @(posedge clock);
			axi_rd(OFF_STAT, st, r);
			chk(32'(st[k]), 32'h1, "sense not caught");
			axi_wr(OFF_STAT, 32'h1 << k, r);
			axi_rd(OFF_STAT, st, r);
			chk(32'(st[k]), 32'h0, "sense not cleared");
		end
		$display("test carrier and collision done");
		close_out;
	end
endmodule
